// [hdl/ewc_pkg.sv]
// package: register map, field positions, reset values and state codes of the wait controller
package ewc_pkg;
    // register word indices; byte address is four times the index
    localparam logic [15:0] IDX_AST       = 16'hfed1;
    localparam logic [15:0] IDX_WCH       = 16'hfed2;
    localparam logic [15:0] IDX_WCL       = 16'hfed3;
    localparam logic [15:0] IDX_BCH       = 16'hfed4;
    localparam logic [15:0] IDX_BCL       = 16'hfed5;
    localparam logic [15:0] IDX_MEM       = 16'hfed6;
    localparam logic [15:0] IDX_RFCNT     = 16'hfed8;
    localparam logic [15:0] IDX_RFCON     = 16'hfed9;
    localparam logic [15:0] IDX_IRQ_STAT  = 16'hfef0;
    localparam logic [15:0] IDX_IRQ_MASK  = 16'hfef1;

    // reset values
    localparam logic [7:0]  RST_AST       = 8'hff;
    localparam logic [7:0]  RST_WAIT      = 8'hff;
    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [7:0]  RST_RFCON     = 8'hff;
    localparam logic [1:0]  RST_IRQ       = 2'h0;

    // field positions
    localparam int          BCH_IDLE_INS  = 7;
    localparam int          BCL_REL_EN    = 1;
    localparam int          MEM_TP_TWO    = 0;
    localparam int          MEM_SELF_MODE = 1;
    localparam int          MEM_RC_WAIT   = 2;
    localparam int          MEM_RFSH_EN   = 3;
    localparam int          MEM_MATCH     = 7;
    localparam int          IRQ_MATCH     = 0;
    localparam int          IRQ_GRANT     = 1;

    // bus state counts
    localparam logic [3:0]  STATES_TWO    = 4'h2;
    localparam logic [3:0]  STATES_THREE  = 4'h3;
    localparam logic [3:0]  TP_ONE        = 4'h1;
    localparam logic [3:0]  TP_TWO        = 4'h2;
    localparam logic [3:0]  RC_WAIT_ONE   = 4'h1;
    localparam logic [3:0]  RAS_LOW_STATES = 4'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_GAP  = 5'b0_0010,
        ST_ACC  = 5'b0_0100,
        ST_REF  = 5'b0_1000,
        ST_REL  = 5'b1_0000
    } ewc_state_e;
endpackage

// [hdl/ewc_pin_sync.sv]
// three-stage synchroniser for a pin; output follows once stages two and three agree
`timescale 1ns/100ps
module ewc_pin_sync (
    // clock, reset and enable
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    // pin and synchronised level
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            // stage one is never looked at here; only agreeing later stages count
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // ewc_pin_sync

// [hdl/ewc_wait_ctrl.sv]
// external bus area wait control: AHB-Lite registers, access sequencer, refresh timer
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module ewc_wait_ctrl
    import ewc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // access request port
    input  wire logic        acc_req,
    input  wire logic [2:0]  acc_area,
    input  wire logic        acc_read,
    output logic             acc_ack,
    output logic             acc_done,
    // external bus
    output logic             ext_cycle,
    output logic [2:0]       ext_area,
    output logic             ext_wait,
    output logic             ras_n,
    output logic             self_refresh,
    output logic             bus_drive,
    output logic             bus_grant,
    input  wire logic        breq_pin,
    // interrupt
    output logic             irq
);
    logic [7:0]  area_access_states;
    logic [7:0]  wait_control_high;
    logic [7:0]  wait_control_low;
    logic [7:0]  bus_control_high;
    logic [7:0]  bus_control_low;
    logic [3:0]  memory_control;
    logic        refresh_match_flag;
    logic        flag_armed;
    logic [7:0]  refresh_timer_count;
    logic [7:0]  refresh_time_constant;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        dp_wr;
    logic [15:0] dp_idx;
    logic [31:0] next_rdata;
    ewc_state_e  st;
    logic [3:0]  step;
    logic [3:0]  cur_len;
    logic        last_rd;
    logic [2:0]  last_area;
    logic        ref_pend;
    logic        grant_evt;
    logic        breq_lvl;

    wire         addr_ok   = hsel && htrans[1] && hready;
    wire         rd_take   = ce && addr_ok && !hwrite;
    wire         wr_en     = ce && dp_wr;
    wire  [7:0]  wb        = hwdata[7:0];
    wire         match     = refresh_timer_count == refresh_time_constant;
    wire         rel_en    = bus_control_low[BCL_REL_EN];
    wire         rfsh_en   = memory_control[MEM_RFSH_EN];
    wire         self_mode = memory_control[MEM_SELF_MODE];
    wire  [3:0]  tp_len    = memory_control[MEM_TP_TWO] ? TP_TWO : TP_ONE;
    wire  [3:0]  ras_at    = tp_len + (memory_control[MEM_RC_WAIT] ? RC_WAIT_ONE : 4'h0);
    wire  [3:0]  ref_len   = ras_at + RAS_LOW_STATES;
    wire         gap_need  = bus_control_high[BCH_IDLE_INS] && acc_read && last_rd
                             && (acc_area != last_area);

    ewc_pin_sync u_breq_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pin     (breq_pin),
        .level   (breq_lvl)
    );

    function automatic logic [3:0] area_len(input logic [2:0] a);
        logic [7:0] wsel;
        logic [1:0] w;
        wsel = a[2] ? wait_control_high : wait_control_low;
        w    = wsel[{a[1:0], 1'b0} +: 2];
        if (!area_access_states[a]) begin
            area_len = STATES_TWO;
        end else begin
            area_len = STATES_THREE + {2'b00, w};
        end
    endfunction

    // bus slave: zero wait states, data phase write, read data registered at address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr     <= 1'b0;
            dp_idx    <= 16'h0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else if (ce) begin
            dp_wr     <= addr_ok && hwrite;
            dp_idx    <= haddr[17:2];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= next_rdata;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[17:2])
            IDX_AST:      next_rdata[7:0] = area_access_states;
            IDX_WCH:      next_rdata[7:0] = wait_control_high;
            IDX_WCL:      next_rdata[7:0] = wait_control_low;
            IDX_BCH:      next_rdata[7:0] = bus_control_high;
            IDX_BCL:      next_rdata[7:0] = bus_control_low;
            IDX_MEM:      next_rdata[7:0] = {refresh_match_flag, 3'b000, memory_control};
            IDX_RFCNT:    next_rdata[7:0] = refresh_timer_count;
            IDX_RFCON:    next_rdata[7:0] = refresh_time_constant;
            IDX_IRQ_STAT: next_rdata[1:0] = irq_stat;
            IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default:      next_rdata = 32'h0000_0000;
        endcase
    end

    // plain control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            area_access_states    <= RST_AST;
            wait_control_high     <= RST_WAIT;
            wait_control_low      <= RST_WAIT;
            bus_control_high      <= RST_ZERO;
            bus_control_low       <= RST_ZERO;
            memory_control        <= RST_ZERO[3:0];
            refresh_time_constant <= RST_RFCON;
            irq_mask              <= RST_IRQ;
        end else if (wr_en) begin
            case (dp_idx)
                IDX_AST:      area_access_states    <= wb;
                IDX_WCH:      wait_control_high     <= wb;
                IDX_WCL:      wait_control_low      <= wb;
                IDX_BCH:      bus_control_high      <= wb;
                IDX_BCL:      bus_control_low       <= wb;
                IDX_MEM:      memory_control        <= wb[3:0];
                IDX_RFCON:    refresh_time_constant <= wb;
                IDX_IRQ_MASK: irq_mask              <= wb[1:0];
                default:      ;
            endcase
        end
    end

    // refresh timer: counts every enabled clock, restarts after a match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refresh_timer_count <= RST_ZERO;
        end else if (ce) begin
            if (wr_en && dp_idx == IDX_RFCNT) begin
                refresh_timer_count <= wb;
            end else if (match) begin
                refresh_timer_count <= RST_ZERO;
            end else begin
                refresh_timer_count <= refresh_timer_count + 8'h01;
            end
        end
    end

    // match flag: a read seeing one arms the clear; a set in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refresh_match_flag <= 1'b0;
            flag_armed         <= 1'b0;
        end else if (ce) begin
            if (rd_take && haddr[17:2] == IDX_MEM && refresh_match_flag) begin
                flag_armed <= 1'b1;
            end else if (wr_en && dp_idx == IDX_MEM && !wb[MEM_MATCH]) begin
                flag_armed <= 1'b0;
            end
            if (match) begin
                refresh_match_flag <= 1'b1;
            end else if (wr_en && dp_idx == IDX_MEM && !wb[MEM_MATCH] && flag_armed) begin
                refresh_match_flag <= 1'b0;
            end
        end
    end

    // interrupt status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= RST_IRQ;
            irq      <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if ((i == IRQ_MATCH && match) || (i == IRQ_GRANT && grant_evt)) begin
                    irq_stat[i] <= 1'b1;
                end else if (wr_en && dp_idx == IDX_IRQ_STAT && wb[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // self refresh is a level, not a sequence, so it is held outside the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            self_refresh <= 1'b0;
            ref_pend     <= 1'b0;
        end else if (ce) begin
            self_refresh <= rfsh_en && self_mode;
            if (match && rfsh_en && !self_mode) begin
                ref_pend <= 1'b1;
            end else if (st == ST_REF) begin
                ref_pend <= 1'b0;
            end
        end
    end

    // access, refresh and release engine; refresh beats release beats access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= ST_IDLE;
            step      <= 4'h0;
            cur_len   <= STATES_TWO;
            acc_ack   <= 1'b0;
            acc_done  <= 1'b0;
            ext_cycle <= 1'b0;
            ext_area  <= 3'h0;
            ext_wait  <= 1'b0;
            ras_n     <= 1'b1;
            bus_drive <= 1'b1;
            bus_grant <= 1'b0;
            grant_evt <= 1'b0;
            last_rd   <= 1'b0;
            last_area <= 3'h0;
        end else if (ce) begin
            acc_ack   <= 1'b0;
            acc_done  <= 1'b0;
            grant_evt <= 1'b0;
            case (st)
                ST_IDLE: begin
                    if (ref_pend) begin
                        st    <= ST_REF;
                        step  <= 4'h0;
                        ras_n <= 1'b1;
                    end else if (breq_lvl && rel_en) begin
                        st        <= ST_REL;
                        bus_grant <= 1'b1;
                        bus_drive <= 1'b0;
                        grant_evt <= 1'b1;
                    end else if (acc_req) begin
                        acc_ack   <= 1'b1;
                        ext_area  <= acc_area;
                        cur_len   <= area_len(acc_area);
                        last_rd   <= acc_read;
                        last_area <= acc_area;
                        step      <= 4'h0;
                        ext_wait  <= 1'b0;
                        if (gap_need) begin
                            st <= ST_GAP;
                        end else begin
                            st        <= ST_ACC;
                            ext_cycle <= 1'b1;
                        end
                    end
                end
                ST_GAP: begin
                    st        <= ST_ACC;
                    ext_cycle <= 1'b1;
                end
                ST_ACC: begin
                    if (step + 4'h1 == cur_len) begin
                        st        <= ST_IDLE;
                        acc_done  <= 1'b1;
                        ext_cycle <= 1'b0;
                        ext_wait  <= 1'b0;
                    end else begin
                        step     <= step + 4'h1;
                        ext_wait <= (step >= 4'h1) && (step + 4'h3 <= cur_len);
                    end
                end
                ST_REF: begin
                    if (step + 4'h1 == ref_len) begin
                        st    <= ST_IDLE;
                        ras_n <= 1'b1;
                    end else begin
                        step  <= step + 4'h1;
                        ras_n <= (step + 4'h1) < ras_at;
                    end
                end
                ST_REL: begin
                    if (!breq_lvl) begin
                        st        <= ST_IDLE;
                        bus_grant <= 1'b0;
                        bus_drive <= 1'b1;
                    end
                end
                default: begin
                    st        <= ST_IDLE;
                    bus_grant <= 1'b0;
                    bus_drive <= 1'b1;
                end
            endcase
        end
    end

    // checks
    sequence s_take;
        ce && st == ST_IDLE && !ref_pend && !(breq_lvl && rel_en) && acc_req;
    endsequence

    property p_two_state;
        @(posedge hclk) disable iff (!hresetn)
        s_take and !area_access_states[acc_area] |=> cur_len == STATES_TWO && acc_ack;
    endproperty
    a_two_state: assert property (p_two_state) else $error("two-state length wrong");

    property p_three_state;
        @(posedge hclk) disable iff (!hresetn)
        s_take and area_access_states[acc_area] |=> cur_len >= STATES_THREE;
    endproperty
    a_three_state: assert property (p_three_state) else $error("three-state length wrong");

    property p_wait_len;
        @(posedge hclk) disable iff (!hresetn)
        ce && st == ST_ACC && step + 4'h1 == cur_len |=> acc_done && st == ST_IDLE;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("access did not end on length");

    property p_idle_gap;
        @(posedge hclk) disable iff (!hresetn)
        s_take and gap_need |=> st == ST_GAP && !ext_cycle ##1 ext_cycle;
    endproperty
    a_idle_gap: assert property (p_idle_gap) else $error("idle cycle missing");

    property p_grant_en;
        @(posedge hclk) disable iff (!hresetn)
        $rose(bus_grant) |-> $past(rel_en);
    endproperty
    a_grant_en: assert property (p_grant_en) else $error("grant without release enable");

    property p_precharge;
        @(posedge hclk) disable iff (!hresetn)
        st == ST_REF && step < tp_len |-> ras_n;
    endproperty
    a_precharge: assert property (p_precharge) else $error("row strobe low in precharge");

    property p_match_set;
        @(posedge hclk) disable iff (!hresetn)
        ce && match |=> refresh_match_flag;
    endproperty
    a_match_set: assert property (p_match_set) else $error("match flag not set");

    property p_flag_clear;
        @(posedge hclk) disable iff (!hresetn)
        $fell(refresh_match_flag) |-> $past(flag_armed) && $past(wr_en);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read");

    property p_no_refresh;
        @(posedge hclk) disable iff (!hresetn)
        !rfsh_en && !ref_pend && st == ST_IDLE |=> st != ST_REF;
    endproperty
    a_no_refresh: assert property (p_no_refresh) else $error("refresh while disabled");

    property p_keep_bus;
        @(posedge hclk) disable iff (!hresetn)
        st == ST_IDLE && !rel_en |=> bus_drive;
    endproperty
    a_keep_bus: assert property (p_keep_bus) else $error("bus released while disabled");
endmodule // ewc_wait_ctrl

// [testbench/ewc_ext_master.sv]
// far-side bus master model: asks for the external bus, drives it only when granted
`timescale 1ns/100ps
module ewc_ext_master (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // request from the bench
    input  wire logic want_bus,
    // arbitration with the device
    input  wire logic bus_grant,
    input  wire logic bus_drive,
    output logic      breq_pin,
    // sticky flag: both sides drove the bus at once
    output logic      clash
);
    // request moves only just after an edge, like a real synchronous master
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            breq_pin <= 1'b0;
        end else begin
            breq_pin <= want_bus;
        end
    end

    // the model drives only while granted and still asking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clash <= 1'b0;
        end else if (bus_grant && breq_pin && bus_drive) begin
            clash <= 1'b1;
        end
    end
endmodule // ewc_ext_master

// [testbench/test_external_bus_area_wait_control.sv]
// self-checking testbench of the external bus area wait controller
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module test_external_bus_area_wait_control;
    import ewc_pkg::*;
    typedef struct {logic [2:0] area; logic [7:0] ast, wch, wcl; int len;} ewc_row_s;
    logic        hclk, hresetn, ce, hsel, hwrite, acc_req, acc_read, want_bus;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize, acc_area, ext_area;
    logic        hreadyout, hresp, acc_ack, acc_done, ext_cycle, ext_wait, ras_n;
    logic        self_refresh, bus_drive, bus_grant, breq_pin, irq, clash;
    int          n_errors, n_compared, cyc, len, wt, dur, d0, d1, d2, w, t;
    // inputs of each row beside the access length they must give
    ewc_row_s    rows[8] = '{'{3'h0, 8'hfe, 8'h00, 8'hff, 2}, '{3'h1, 8'hff, 8'h00, 8'h04, 4},
                         '{3'h2, 8'hff, 8'h00, 8'h20, 5}, '{3'h3, 8'hff, 8'h00, 8'hc0, 6},
                         '{3'h4, 8'hff, 8'h03, 8'h00, 6}, '{3'h5, 8'hdf, 8'hff, 8'h00, 2},
                         '{3'h6, 8'hff, 8'h20, 8'h00, 5}, '{3'h7, 8'hff, 8'h00, 8'h00, 3}};
    // last index is unmapped and must read zero
    logic [15:0] ridx[9] = '{IDX_AST, IDX_WCH, IDX_WCL, IDX_BCH, IDX_BCL, IDX_MEM, IDX_RFCON,
                            IDX_IRQ_MASK, 16'hfed7};
    logic [7:0]  rval[9] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};

    ewc_wait_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .acc_req(acc_req),
        .acc_area(acc_area), .acc_read(acc_read), .acc_ack(acc_ack), .acc_done(acc_done),
        .ext_cycle(ext_cycle), .ext_area(ext_area), .ext_wait(ext_wait), .ras_n(ras_n),
        .self_refresh(self_refresh), .bus_drive(bus_drive), .bus_grant(bus_grant),
        .breq_pin(breq_pin), .irq(irq));
    ewc_ext_master u_master (.hclk(hclk), .hresetn(hresetn), .want_bus(want_bus),
        .bus_grant(bus_grant), .bus_drive(bus_drive), .breq_pin(breq_pin), .clash(clash));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic results();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            results();
        end
    end

    // one single word transfer; entered and left right after a rising edge
    task automatic ahb(input logic [15:0] idx, input logic wr, input logic [7:0] d,
                       output logic [31:0] r);
        int k;
        k = 0;
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 50) begin @(posedge hclk); k++; end
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 50) begin @(posedge hclk); k++; end
        r = hrdata;
        `CHK({hresp, k < 50}, 2'b01)
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        ahb(idx, 1'b1, d, r);
    endtask

    task automatic chk_rd(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] r;
        ahb(idx, 1'b0, 8'h00, r);
        `CHK(r, {24'h0, e})
    endtask

    // one access: states with ext_cycle, wait states, and cycles from ack to done
    task automatic acc(input logic [2:0] a, input logic rd, output int n, output int wn,
                       output int dn);
        int k;
        k = 0; n = 0; wn = 0; dn = 0;
        acc_req  <= 1'b1;
        acc_area <= a;
        acc_read <= rd;
        @(posedge hclk);
        while (acc_ack !== 1'b1 && k < 300) begin @(posedge hclk); k++; end
        acc_req <= 1'b0;
        `CHK(ext_area, a)
        do begin
            n  += int'(ext_cycle === 1'b1);
            wn += int'(ext_wait === 1'b1);
            @(posedge hclk);
            dn++;
        end while (acc_done !== 1'b1 && dn < 40);
    endtask

    // waits for the next match, then times the row strobe against it
    task automatic rfsh(input logic [7:0] m, output int dd, output int wl);
        int k;
        k = 0; dd = 0; wl = 0;
        wr(IDX_MEM, m);
        // restart the timer so no match can land on the status clear below
        wr(IDX_RFCNT, 8'h00);
        wr(IDX_IRQ_STAT, 8'h01);
        // irq lags the status by a cycle, so let the clear reach it first
        repeat (2) @(posedge hclk);
        while (irq !== 1'b1 && k < 300) begin @(posedge hclk); k++; end
        while (ras_n === 1'b1 && dd < 20) begin @(posedge hclk); dd++; end
        while (ras_n === 1'b0 && wl < 20) begin @(posedge hclk); wl++; end
    endtask

    initial begin
        hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = '0; acc_req = 1'b0; acc_area = '0; acc_read = 1'b0;
        want_bus = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            wr(IDX_AST, rows[i].ast);
            wr(IDX_WCH, rows[i].wch);
            wr(IDX_WCL, rows[i].wcl);
            acc(rows[i].area, 1'b0, len, wt, dur);
            `CHK(len, rows[i].len)
            `CHK(wt, (rows[i].len > 2) ? rows[i].len - 3 : 0)
            `CHK(dur, rows[i].len)
        end
        // second reset in mid-run, then register reset values
        hresetn <= 1'b0;
        @(posedge hclk);
        @(posedge hclk);
        `CHK({bus_drive, bus_grant, ras_n, irq, ext_cycle}, 5'b10100)
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ridx[i]) chk_rd(ridx[i], rval[i]);
        // idle gap only between reads of different areas while enabled
        wr(IDX_AST, 8'h00);
        wr(IDX_BCH, 8'h80);
        acc(3'h1, 1'b1, len, wt, dur);
        acc(3'h2, 1'b1, len, wt, dur);
        `CHK(dur, 3)
        acc(3'h2, 1'b1, len, wt, dur);
        `CHK(dur, 2)
        wr(IDX_BCH, 8'h00);
        acc(3'h1, 1'b1, len, wt, dur);
        `CHK(dur, 2)
        // outside master asks while release is off, then on
        want_bus <= 1'b1;
        repeat (20) @(posedge hclk);
        `CHK({bus_grant, bus_drive}, 2'b01)
        wr(IDX_IRQ_MASK, 8'h02);
        wr(IDX_BCL, 8'h02);
        repeat (10) @(posedge hclk);
        `CHK({bus_grant, bus_drive, irq}, 3'b101)
        ahb(IDX_IRQ_STAT, 1'b0, 8'h00, q);
        `CHK(q[1], 1'b1)
        want_bus <= 1'b0;
        repeat (10) @(posedge hclk);
        `CHK({bus_grant, bus_drive}, 2'b01)
        wr(IDX_BCL, 8'h00);
        wr(IDX_IRQ_STAT, 8'h03);
        // match period shortened so the flag sets within the run
        wr(IDX_RFCON, 8'h40);
        chk_rd(IDX_RFCON, 8'h40);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b0)
        wr(IDX_RFCNT, 8'h00);
        t = 0;
        while (irq !== 1'b1 && t < 300) begin @(posedge hclk); t++; end
        `CHK(t inside {[60:70]}, 1'b1)
        wr(IDX_MEM, 8'h00);
        chk_rd(IDX_MEM, 8'h80);
        wr(IDX_MEM, 8'h00);
        chk_rd(IDX_MEM, 8'h00);
        wr(IDX_IRQ_STAT, 8'h01);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b0)
        // refresh: off, cas-before-ras, longer precharge, ras-cas wait, self mode
        rfsh(8'h00, d0, w);
        `CHK(w, 0)
        rfsh(8'h08, d0, w);
        `CHK(w, 2)
        rfsh(8'h09, d1, w);
        `CHK(d1 - d0, 1)
        rfsh(8'h0d, d2, w);
        `CHK(d2 - d1, 1)
        rfsh(8'h0a, d2, w);
        `CHK({w == 0, self_refresh}, 2'b11)
        `CHK(clash, 1'b0)
        results();
    end
endmodule // test_external_bus_area_wait_control
